// ---- verilog/stc_pkg.sv ----
// constants, types and helpers of the sysref timing calibration block
// Functional notes
// - enable low: manual aperture delay drives clock
// - enable high: calibrated delay, manual ignored
// - calibration starts only on enable rising
// - calibration ends within unit times (code sum plus two)
// - averaging code selects 4/16/64/256 accumulations
// - length code selects 4/16/64/256 cycle accumulations
// - too long sysref period fails the calibration
// - config resets to 05 hex
// - done flag bit 17, enable and complete
// - 17-bit result: invert, coarse, fine
`default_nettype none
package stc_pkg;
  // register word indices; byte address is four times these
  localparam logic [9:0] IDX_EN      = 10'h2B0;
  localparam logic [9:0] IDX_CFG     = 10'h2B1;
  localparam logic [9:0] IDX_STAT    = 10'h2B2;
  localparam logic [9:0] IDX_MAN     = 10'h2B5;
  localparam logic [9:0] IDX_IRQ_ST  = 10'h2B8;
  localparam logic [9:0] IDX_IRQ_MSK = 10'h2B9;
  // values after reset
  localparam logic [7:0] EN_RST      = 8'h00;
  localparam logic [7:0] CFG_RST     = 8'h05;
  // field positions
  localparam int EN_BIT        = 0;
  localparam int CFG_AVG_LSB   = 2;
  localparam int CFG_LEN_LSB   = 0;
  localparam int STAT_DONE_BIT = 17;
  localparam int RES_INV_BIT   = 16;
  localparam int RES_W         = 17;
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_FAIL_BIT  = 1;
  // cycle counts
  localparam int CAL_UNIT_CYC  = 256 * 19 * 4;
  localparam int PER_LIM_C0    = 85;
  localparam int PER_LIM_C1    = 1100;
  localparam int PER_LIM_C2    = 5200;
  localparam int PER_LIM_C3    = 21580;
  // engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b10,
    ST_FAIL = 2'b11
  } stc_state_t;
  // both codes map 0..3 onto 4, 16, 64, 256
  function automatic logic [8:0] acc_len(input logic [1:0] code);
    acc_len = 9'(9'h004 << {code, 1'b0});
  endfunction
  // log2 of acc_len
  function automatic logic [3:0] acc_shift(input logic [1:0] code);
    acc_shift = {1'b0, code, 1'b0} + 4'h2;
  endfunction
  // byte-lane merge of a write into the current word
  function automatic logic [31:0] wmerge(input logic [31:0] cur, input logic [31:0] wd,
                                         input logic [3:0] strb);
    wmerge = cur;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) wmerge[i*8 +: 8] = wd[i*8 +: 8];
    end
  endfunction
endpackage
`default_nettype wire

// ---- verilog/stc_edge_watch.sv ----
// sysref synchroniser, rising-edge detector and period watchdog
`timescale 1ns/1ns
`default_nettype none
module stc_edge_watch (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        sysref_in,
  input  wire logic        clear,
  input  wire logic [14:0] limit,
  output logic             edge_pulse,
  output logic             period_over
);
  // all state in one word
  typedef struct packed {
    logic        s1;     // first sync stage, read by s2 only
    logic        s2;     // second sync stage
    logic        s3;     // delayed copy for edge detect
    logic        edge_q; // registered rising edge
    logic [15:0] cnt;    // cycles since last edge, saturating
    logic        over;   // gap longer than limit
  } stc_watch_t;

  stc_watch_t w_r;
  stc_watch_t w_nxt;

  // next-state logic
  always_comb begin
    w_nxt        = w_r;
    w_nxt.s1     = sysref_in;
    w_nxt.s2     = w_r.s1;
    w_nxt.s3     = w_r.s2;
    w_nxt.edge_q = w_r.s2 && !w_r.s3;
    // restart the gap count on every edge or on request
    if (clear || (w_r.s2 && !w_r.s3)) begin
      w_nxt.cnt = 16'h0000;
    end else if (w_r.cnt != 16'hFFFF) begin
      w_nxt.cnt = w_r.cnt + 16'h0001;
    end
    // a gap beyond the supported period flags failure
    w_nxt.over = !clear && (w_r.cnt > {1'b0, limit});
  end

  // state register, synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      w_r <= '0;
    end else begin
      w_r <= w_nxt;
    end
  end

  assign edge_pulse  = w_r.edge_q;
  assign period_over = w_r.over;
endmodule // stc_edge_watch
`default_nettype wire

// ---- verilog/stc_sysref_cal.sv ----
// sysref timing calibration controller with apb registers
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module stc_sysref_cal
  import stc_pkg::*;
#(
  parameter int CAL_UNIT = CAL_UNIT_CYC, // cycles per code step of the time bound
  parameter int PER_LIM0 = PER_LIM_C0,   // longest period, length code 0
  parameter int PER_LIM1 = PER_LIM_C1,   // longest period, length code 1
  parameter int PER_LIM2 = PER_LIM_C2,   // longest period, length code 2
  parameter int PER_LIM3 = PER_LIM_C3    // longest period, length code 3
) (
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sysref_in,
  output logic      [RES_W-1:0]  aperture_delay_adjust,
  output logic                   cal_busy,
  output logic                   irq
);
  // refuse parameters that overflow the counters
  if (CAL_UNIT < 1 || CAL_UNIT * 8 >= 262144) begin : g_bad_unit
    $error("calibration time unit out of range");
  end
  if (PER_LIM0 < 1 || PER_LIM1 < 1 || PER_LIM2 < 1 || PER_LIM3 < 1 ||
      PER_LIM0 > 32767 || PER_LIM1 > 32767 || PER_LIM2 > 32767 ||
      PER_LIM3 > 32767) begin : g_bad_lim
    $error("sysref period limit out of range");
  end

  // all state of the block in one word
  typedef struct packed {
    stc_state_t       state;   // engine state
    logic             en;      // calibration enable bit
    logic             en_d;    // enable one cycle ago
    logic [7:0]       cfg;     // configuration register
    logic [1:0]       avg;     // averaging code latched at start
    logic [1:0]       len;     // length code latched at start
    logic [RES_W-1:0] man;     // manual aperture delay
    logic [RES_W-1:0] res;     // calibrated delay result
    logic [RES_W-1:0] dly;     // delay applied to the clock
    logic [7:0]       phase;   // position inside an accumulation
    logic             hit;     // edge already seen this window
    logic [15:0]      sum;     // sum of edge positions
    logic [8:0]       cnt;     // accumulations completed
    logic [17:0]      tmo;     // cycles since start
    logic [1:0]       irq_st;  // sticky event bits
    logic [1:0]       irq_msk; // event mask
    logic             irq;     // interrupt level
    logic [31:0]      rdata;   // read data held for access phase
  } stc_regs_t;

  stc_regs_t st_r;
  stc_regs_t st_nxt;

  logic        apb_setup;  // setup phase of any transfer
  logic        apb_acc;    // access phase of any transfer
  logic [9:0]  word_idx;   // word index of the address
  logic        map_ok;     // address hits a register
  logic [31:0] rd_val;     // current value of the addressed word
  logic [31:0] wv;         // merged write value
  logic [1:0]  w1c;        // bits cleared by this write
  logic        done_flag;  // enabled and complete
  logic        start_pls;  // one cycle at enable rise
  logic        sr_edge;    // synchronised sysref rising edge
  logic        per_over;   // sysref gap beyond limit
  logic [14:0] per_lim;    // limit for latched length code
  logic [8:0]  len_c;      // cycles per accumulation
  logic [8:0]  nacc;       // accumulations per measurement
  logic [17:0] tmo_bound;  // cycle bound for this run
  logic [15:0] sum_new;    // sum including this cycle's edge
  logic        got;        // window saw an edge
  logic [23:0] q;          // mean edge position, 8 fraction bits
  logic [15:0] half;       // half a window, same scale
  logic        ev_done;    // calibration finished event
  logic        ev_fail;    // calibration failed event

  // sysref edge detection and period watchdog
  stc_edge_watch u_watch (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .sysref_in   (sysref_in),
    .clear       (start_pls),
    .limit       (per_lim),
    .edge_pulse  (sr_edge),
    .period_over (per_over)
  );

  // apb decode
  assign apb_setup = psel && !penable;
  assign apb_acc   = psel && penable;
  assign word_idx  = paddr[11:2];
  assign map_ok    = (word_idx == IDX_EN) || (word_idx == IDX_CFG) ||
                     (word_idx == IDX_STAT) || (word_idx == IDX_MAN) ||
                     (word_idx == IDX_IRQ_ST) || (word_idx == IDX_IRQ_MSK);
  // zero wait states; unmapped words answer with an error
  assign pready    = 1'b1;
  assign pslverr   = apb_acc && !map_ok;
  assign prdata    = st_r.rdata;

  // done only while enabled and the engine has finished
  assign done_flag = st_r.en && (st_r.state == ST_DONE);
  assign start_pls = st_r.en && !st_r.en_d;
  assign cal_busy  = (st_r.state == ST_RUN);
  assign aperture_delay_adjust = st_r.dly;
  assign irq       = st_r.irq;

  // per-run settings from the latched codes
  always_comb begin
    len_c = acc_len(st_r.len);
    nacc  = acc_len(st_r.avg);
    half  = {st_r.len == 2'b11 ? 8'h80 : len_c[8:1], 8'h00};
    // bound grows with both codes
    tmo_bound = 18'(CAL_UNIT) * 18'({2'b00, st_r.avg} + {2'b00, st_r.len} + 4'h2);
    case (st_r.len)
      2'b00:   per_lim = 15'(PER_LIM0);
      2'b01:   per_lim = 15'(PER_LIM1);
      2'b10:   per_lim = 15'(PER_LIM2);
      default: per_lim = 15'(PER_LIM3);
    endcase
  end

  // read mux; reserved bits read as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case (word_idx)
      IDX_EN:      rd_val[EN_BIT] = st_r.en;
      IDX_CFG:     rd_val[7:0] = st_r.cfg;
      IDX_STAT: begin
        rd_val[RES_W-1:0]    = st_r.res;
        rd_val[STAT_DONE_BIT] = done_flag;
      end
      IDX_MAN:     rd_val[RES_W-1:0] = st_r.man;
      IDX_IRQ_ST:  rd_val[1:0] = st_r.irq_st;
      IDX_IRQ_MSK: rd_val[1:0] = st_r.irq_msk;
      default:     rd_val = 32'h0000_0000;
    endcase
  end

  // next-state logic of registers and engine
  always_comb begin
    st_nxt  = st_r;
    ev_done = 1'b0;
    ev_fail = 1'b0;
    wv      = wmerge(rd_val, pwdata, pstrb);
    w1c     = 2'b00;
    sum_new = st_r.sum;
    got     = st_r.hit;
    q       = 24'h00_0000;

    // read data captured in setup so it stands through access
    if (apb_setup && !pwrite) begin
      st_nxt.rdata = rd_val;
    end

    // register writes take effect in the access phase
    if (apb_acc && pwrite && map_ok) begin
      case (word_idx)
        IDX_EN:      st_nxt.en = wv[EN_BIT];
        IDX_CFG:     st_nxt.cfg = wv[7:0];
        IDX_MAN:     st_nxt.man = wv[RES_W-1:0];
        IDX_IRQ_ST:  w1c = pwdata[1:0] & {2{pstrb[0]}};
        IDX_IRQ_MSK: st_nxt.irq_msk = wv[1:0];
        default:     st_nxt.rdata = st_r.rdata; // status is read only
      endcase
    end

    st_nxt.en_d = st_r.en;

    // engine
    if (!st_r.en) begin
      // disabled: idle, done cleared
      st_nxt.state = ST_IDLE;
    end else if (!st_r.en_d) begin
      // rising enable starts a fresh sequence
      st_nxt.state = ST_RUN;
      st_nxt.avg   = st_r.cfg[CFG_AVG_LSB +: 2];
      st_nxt.len   = st_r.cfg[CFG_LEN_LSB +: 2];
      st_nxt.phase = 8'h00;
      st_nxt.hit   = 1'b0;
      st_nxt.sum   = 16'h0000;
      st_nxt.cnt   = 9'h000;
      st_nxt.tmo   = 18'h0_0000;
    end else begin
      case (st_r.state)
        ST_RUN: begin
          st_nxt.tmo = st_r.tmo + 18'h0_0001;
          // first edge in a window adds its position
          if (sr_edge && !st_r.hit) begin
            sum_new = 16'(st_r.sum + {8'h00, st_r.phase});
            got     = 1'b1;
          end
          q = 24'({sum_new, 8'h00} >> acc_shift(st_r.avg));
          if (per_over) begin
            // period beyond supported length: no result
            st_nxt.state = ST_FAIL;
            ev_fail      = 1'b1;
          end else if (st_r.tmo >= tmo_bound - 18'h0_0001) begin
            // out of time: give up at the bound
            st_nxt.state = ST_FAIL;
            ev_fail      = 1'b1;
          end else if ({1'b0, st_r.phase} == len_c - 9'h001) begin
            // window of len_c cycles ends
            st_nxt.phase = 8'h00;
            st_nxt.hit   = 1'b0;
            st_nxt.sum   = sum_new;
            if (got) begin
              if (st_r.cnt == nacc - 9'h001) begin
                // last accumulation of the measurement
                st_nxt.state = ST_DONE;
                ev_done      = 1'b1;
                // late half of the window means inverted clock
                if (q[15:0] >= half) begin
                  st_nxt.res = {1'b1, 16'(q[15:0] - half)};
                end else begin
                  st_nxt.res = {1'b0, q[15:0]};
                end
              end else begin
                st_nxt.cnt = st_r.cnt + 9'h001;
              end
            end
            // windows without an edge are retried, not counted
          end else begin
            st_nxt.phase = st_r.phase + 8'h01;
            st_nxt.hit   = got;
            st_nxt.sum   = sum_new;
          end
        end
        ST_IDLE: st_nxt.state = ST_IDLE;
        ST_DONE: st_nxt.state = ST_DONE;
        ST_FAIL: st_nxt.state = ST_FAIL;
        default: st_nxt.state = ST_IDLE;
      endcase
    end

    // applied delay: manual when off, calibrated when on
    st_nxt.dly = st_r.en ? st_r.res : st_r.man;

    // sticky events; a set in the clearing cycle wins
    st_nxt.irq_st = (st_r.irq_st & ~w1c) |
                    {ev_fail, 1'b0} | {1'b0, ev_done};
    st_nxt.irq    = |(st_nxt.irq_st & st_nxt.irq_msk);
  end

  // state register, synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r     <= '0;
      st_r.en  <= EN_RST[EN_BIT];
      st_r.cfg <= CFG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  a_manual_delay_path: assert property (
    !st_r.en |=> aperture_delay_adjust == $past(st_r.man))
    else $error("manual delay not applied while disabled");

  a_auto_delay_path: assert property (
    (st_r.en && $stable(st_r.man) && $stable(st_r.res)) [*2] |->
      aperture_delay_adjust == st_r.res)
    else $error("calibrated delay not applied while enabled");

  a_start_on_rise: assert property (
    $rose(st_r.state == ST_RUN) |-> $past(st_r.en) && !$past(st_r.en_d))
    else $error("calibration started without enable rise");

  a_rise_starts_run: assert property (
    (st_r.en && !st_r.en_d) |=> st_r.state == ST_RUN)
    else $error("enable rise did not start calibration");

  a_time_bound: assert property (
    st_r.state == ST_RUN |-> st_r.tmo < tmo_bound)
    else $error("calibration ran past its time bound");

  a_window_len: assert property (
    (st_r.state == ST_RUN && st_r.en && !per_over && st_r.tmo < tmo_bound - 18'h0_0001 &&
     {1'b0, st_r.phase} == len_c - 9'h001) |=>
      st_r.phase == 8'h00)
    else $error("accumulation window length wrong");

  a_avg_count: assert property (
    $rose(st_r.state == ST_DONE) |-> $past(st_r.cnt) == $past(nacc) - 9'h001)
    else $error("measurement finished with wrong accumulation count");

  a_period_fail: assert property (
    (st_r.state == ST_RUN && st_r.en && st_r.en_d && per_over) |=>
      st_r.state == ST_FAIL ##1 !done_flag)
    else $error("long sysref period did not fail");

  a_cfg_reset: assert property (
    $past(!reset_n) |-> st_r.cfg == CFG_RST && !st_r.en)
    else $error("configuration reset value wrong");

  a_done_clear: assert property (
    !st_r.en |=> !done_flag)
    else $error("done flag survived disable");

  a_result_hold: assert property (
    (done_flag && $past(done_flag)) |-> $stable(st_r.res))
    else $error("result changed while done");

  c_cal_done: cover property ($rose(done_flag));
  c_cal_fail: cover property ($rose(st_r.state == ST_FAIL));
  c_irq_raise: cover property ($rose(irq));
  c_restart: cover property (done_flag ##1 !st_r.en ##[1:20] st_r.state == ST_RUN);
endmodule // stc_sysref_cal
`default_nettype wire

// ---- bench/stc_sysref_src.sv ----
// behavioural sysref source standing at the far side of the block
`timescale 1ns/1ns
`default_nettype none
module stc_sysref_src (
  input  wire logic        run,     // low stalls the source
  input  wire logic [15:0] half_ns, // half period in ns, never zero
  output logic             sysref   // sysref pin level
);
  // free of sys_clk on purpose, so edges land at any phase; one process drives the pin
  initial begin
    sysref = 1'b0;
    forever begin
      #(half_ns);
      sysref = run ? ~sysref : 1'b0; // period kept far below the length limit
    end
  end
endmodule // stc_sysref_src
`default_nettype wire

// ---- bench/tb_stc_sysref_cal.sv ----
// self-checking bench of the sysref timing calibration block
`timescale 1ns/1ns
`default_nettype none
module tb_stc_sysref_cal
  import stc_pkg::*;
;
  localparam int UNIT = 1024;           // shortened time unit; six units still above 64 x 64 accumulation cycles
  localparam int WAIT_CAP = 10000;      // longest wait for an outcome, beyond every bound used
  localparam logic [16:0] MANV = 17'h12A5C; // manual delay pattern
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  pstrb   = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sysref_in;
  logic [16:0] aperture_delay_adjust;
  logic        cal_busy;
  logic        irq;
  logic        src_run = 1'b1;          // partner running
  int          n_errors = 0;
  int          n_tests = 0;
  always #5 sys_clk = ~sys_clk;
  stc_sysref_cal #(.CAL_UNIT(UNIT)) stc_sysref_cal_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sysref_in(sysref_in), .aperture_delay_adjust(aperture_delay_adjust),
    .cal_busy(cal_busy), .irq(irq));
  stc_sysref_src stc_sysref_src_inst (.run(src_run), .half_ns(16'h0013), .sysref(sysref_in));
  // one comparison, counted
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // one apb transfer; request held until pready seen at an edge
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= {idx, 2'b00};
    pwrite <= wr;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) check(1'b0, "pready never came");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask
  task automatic rd(input logic [9:0] idx, output logic [31:0] r);
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
  endtask
  // fresh start: disable, clear flags, program config, then enable
  task automatic start_cal(input logic [1:0] avg, input logic [1:0] len);
    wr(IDX_EN, 32'h0);
    wr(IDX_IRQ_ST, 32'h3);
    wr(IDX_CFG, {28'h0, avg, len}); // config before enable
    wr(IDX_EN, 32'h1); // no converter calibration runs in this bench
  endtask
  // cycles until the interrupt rises, bounded
  task automatic wait_irq(output int cyc);
    cyc = 0;
    while (irq !== 1'b1 && cyc < WAIT_CAP) begin
      @(posedge sys_clk);
      cyc++;
    end
  endtask
  task automatic test_reset();
    logic [31:0] r;
    logic e;
    rd(IDX_EN, r);
    check(r === 32'h0, "enable reset value");
    rd(IDX_CFG, r);
    check(r === 32'h5, "config reset value");
    rd(IDX_STAT, r);
    check(r[17] === 1'b0, "done set after reset");
    check(irq === 1'b0 && aperture_delay_adjust === 17'h0, "outputs after reset");
    apb(1'b1, 10'h2B3, 32'hFF, r, e);
    check(e === 1'b1, "unmapped write not refused");
    apb(1'b0, 10'h2B3, 32'h0, r, e);
    check(e === 1'b1 && r === 32'h0, "unmapped read");
    $display("test reset done");
  endtask
  task automatic test_manual();
    wr(IDX_MAN, {15'h0, MANV});
    wr(IDX_IRQ_MSK, 32'h3);
    repeat (2) @(posedge sys_clk);
    check(aperture_delay_adjust === MANV, "manual delay not applied");
    $display("test manual done");
  endtask
  // every code of both fields, duration against both bounds
  task automatic test_timing();
    logic [1:0] cfg [4][2];
    logic [31:0] r;
    int cyc;
    int nacc;
    int alen;
    cfg = '{'{2'd1, 2'd1}, '{2'd3, 2'd0}, '{2'd0, 2'd3}, '{2'd2, 2'd2}};
    for (int i = 0; i < 4; i++) begin
      nacc = 4 << (2 * cfg[i][0]);
      alen = 4 << (2 * cfg[i][1]);
      start_cal(cfg[i][0], cfg[i][1]);
      wait_irq(cyc);
      check(cyc <= UNIT * (cfg[i][0] + cfg[i][1] + 2) + 4, "calibration too slow");
      check(cyc >= nacc * alen, "calibration shorter than its accumulations");
      rd(IDX_IRQ_ST, r);
      check(r[1:0] === 2'b01, "calibration did not report done");
      rd(IDX_STAT, r);
      check(r[17] === 1'b1 && cal_busy === 1'b0, "done flag missing");
      check(aperture_delay_adjust === r[16:0], "result not applied");
      check(aperture_delay_adjust !== MANV, "manual delay used while enabled");
    end
    $display("test timing done");
  endtask
  task automatic test_rerun();
    logic [31:0] r;
    int cyc;
    wr(IDX_EN, 32'h1);
    repeat (2) @(posedge sys_clk);
    check(cal_busy === 1'b0, "enable held high restarted");
    rd(IDX_STAT, r);
    check(r[17] === 1'b1, "done lost on repeated enable");
    wr(IDX_MAN, {15'h0, r[16:0]}); // copy result for later boots
    wr(IDX_EN, 32'h0);
    repeat (2) @(posedge sys_clk);
    check(aperture_delay_adjust === r[16:0], "copied manual delay not applied");
    rd(IDX_STAT, r);
    check(r[17] === 1'b0, "done kept after disable");
    start_cal(2'd0, 2'd2);
    repeat (2) @(posedge sys_clk);
    check(cal_busy === 1'b1, "rising enable did not start");
    rd(IDX_STAT, r);
    check(r[17] === 1'b0, "done set during rerun");
    wait_irq(cyc);
    check(cyc < WAIT_CAP, "rerun did not finish");
    $display("test rerun done");
  endtask
  task automatic test_irq();
    logic [31:0] r;
    int n;
    n = 0;
    wr(IDX_IRQ_MSK, 32'h0);
    start_cal(2'd0, 2'd0);
    repeat (3) @(posedge sys_clk);
    while (cal_busy === 1'b1 && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (2) @(posedge sys_clk);
    check(irq === 1'b0, "masked event raised irq");
    rd(IDX_IRQ_ST, r);
    check(r[0] === 1'b1, "done event not latched");
    wr(IDX_IRQ_MSK, 32'h1);
    @(posedge sys_clk);
    check(irq === 1'b1, "unmasked event gives no irq");
    wr(IDX_IRQ_ST, 32'h1);
    @(posedge sys_clk);
    check(irq === 1'b0, "irq stays after clear");
    rd(IDX_IRQ_ST, r);
    check(r[0] === 1'b0, "status not cleared by one");
    wr(IDX_IRQ_MSK, 32'h3);
    $display("test irq done");
  endtask
  // stalled source: period beyond every limit must fail; then an overlong run must fail at the time bound
  task automatic test_fail();
    logic [31:0] r;
    int cyc;
    src_run <= 1'b0; // period limit broken on purpose
    start_cal(2'd0, 2'd0);
    wait_irq(cyc);
    check(cyc < WAIT_CAP, "no outcome on stalled sysref");
    rd(IDX_IRQ_ST, r);
    check(r[1:0] === 2'b10, "stalled sysref did not fail");
    rd(IDX_STAT, r);
    check(r[17] === 1'b0, "done set on failure");
    src_run <= 1'b1;
    // 256 windows of 256 cycles cannot fit the bound: must fail at it
    start_cal(2'd3, 2'd3);
    wait_irq(cyc);
    check(cyc >= UNIT * 8 && cyc <= UNIT * 8 + 4, "timeout not taken at the bound");
    rd(IDX_IRQ_ST, r);
    check(r[1:0] === 2'b10, "overlong calibration did not fail");
    $display("test fail done");
  endtask
  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    test_reset();
    test_manual();
    test_timing();
    test_rerun();
    test_irq();
    test_fail();
    print_verdict();
  end
  // watchdog, far beyond the expected run of some fifteen thousand cycles
  initial begin
    #400000;
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule // tb_stc_sysref_cal
`default_nettype wire
